// ===== rtl/rps_pkg.sv
// Types shared by the rail power sequencer.
// Needs nothing from rps_regs.svh; its numeric constants are local.
package rps_pkg;
  // Rail order: buck 1..4, general linear regulator, load switches one..three, backup a, b.
  localparam int RPS_NRAIL = 10;
  localparam int RPS_NDELAY = 9;
  typedef logic [RPS_NRAIL-1:0] rps_rails_t;
  // Global control bits.
  typedef struct packed {
    logic long_press_select;
    logic backup_rail_seal;
    logic shutdown_delay_multiplier;
  } rps_ctrl_t;
  // Power states, one-hot.
  typedef enum logic [5:0] {
    RPS_OFF      = 6'h01,
    RPS_WAIT     = 6'h02,
    RPS_ACTIVE   = 6'h04,
    RPS_SUSPEND  = 6'h08,
    RPS_RECOVERY = 6'h10,
    RPS_SHUTDOWN = 6'h20
  } rps_state_t;
endpackage

// ===== rtl/rps_regs.svh
// Register offsets, field defaults and timing figures of the rail power sequencer.
// Assumes a single 40 MHz clock and a 1 ms internal timebase.
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH
`define RPS_A_CTRL       8'h00
`define RPS_A_ENABLE     8'h01
`define RPS_A_CODE0      8'h02
`define RPS_A_CODE9      8'h0b
`define RPS_A_DELAY0     8'h0c
`define RPS_A_DELAY8     8'h14
`define RPS_A_STATUS     8'h15
`define RPS_CTRL_RESET   3'h0
`define RPS_CODE_RESET   40'h2100876543
`define RPS_DELAY_RESET  8'h02
`define RPS_DELAY_MIN    8'h02
`define RPS_DELAY_MAX    8'h05
`define RPS_DOWN_FACTOR  8'h0a
`define RPS_STEP_NONE    4'h0
`define RPS_STEP_FIRST   4'h1
`define RPS_STEP_BACKUP  4'h2
`define RPS_STEP_SEALED  4'h3
`define RPS_STEP_LAST    4'ha
`define RPS_BACKUP_A     8
`define RPS_UNSEQ_TOP    6
`define RPS_LS_TWO       6
`define RPS_LS_THREE     7
`define RPS_CLK_HZ       40000000
`define RPS_TICKS_PER_S  1000
`define RPS_WAIT_MS      15'd20000
`define RPS_LONG_MS      15'd8000
`define RPS_LONGER_MS    15'd15000
`define RPS_DOWN_MS      15'd500
`define RPS_MS_MAX       15'h7fff
`endif

// ===== rtl/rps_top.sv
// Rail power sequencer: power state machine, step sequencer and register port.
// Assumes all pin inputs are synchronous to CLK and register strobes are one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rps_regs.svh"

module rps_top
  import rps_pkg::*;
#(
  // Clock cycles per timebase tick; shorten in simulation.
  parameter int TICK_CYCLES = `RPS_CLK_HZ / `RPS_TICKS_PER_S
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Register port.
  input  wire logic [7:0]  ADDR,
  input  wire logic [15:0] WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output var  logic [15:0] RD_DATA,
  // Wake and fault inputs.
  input  wire logic        POWER_BUTTON,
  input  wire logic        SUPPLY_DETECT_PIN,
  input  wire logic        HOST_POWER_REQUEST,
  input  wire logic        MAIN_SUPPLY_PRESENT,
  input  wire logic        MAIN_SUPPLY_FAIL,
  input  wire logic        SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input  wire logic        THERMAL_SHUTDOWN,
  input  wire logic        RAILS_IN_REGULATION,
  // Rail controls and status.
  output var  logic [9:0]  RAIL_ENABLE,
  output var  logic [9:0]  RAIL_DISCHARGE,
  output var  logic [5:0]  STATE,
  output var  logic        SEQUENCER_BUSY
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam logic [15:0] TICK_TOP = 16'(TICK_CYCLES - 1); // Last cycle of a tick.
  localparam logic [39:0] CODE_RESET = `RPS_CODE_RESET;    // Reset step codes, rail 0 lowest.

  logic        core_rst;                  // Pin reset or supply failure.
  rps_ctrl_t   ctrl_reg;                  // Global control bits.
  logic [3:0]  code_reg [RPS_NRAIL];      // Step code of each rail.
  logic [7:0]  delay_reg [RPS_NDELAY];    // Step delays in ms.
  rps_rails_t  en_reg;                    // Rail enables.
  rps_rails_t  dis_reg;                   // Rail discharge controls.
  rps_state_t  state_reg;                 // Power state.
  rps_state_t  state_next;                // Next power state.
  rps_state_t  target_reg;                // Where power-down ends.
  rps_state_t  target_next;               // Target chosen this cycle.
  logic        up_start;                  // Power-up begins this cycle.
  logic        down_start;                // Power-down begins this cycle.
  logic        down_end;                  // Power-down window ends this cycle.
  logic        pb_reg;                    // Button, one cycle late.
  logic        sd_reg;                    // Supply detect, one cycle late.
  logic        hpr_reg;                   // Host request, one cycle late.
  logic        pb_fall;                   // Button pressed.
  logic        sd_fall;                   // Supply detect pulled low.
  logic        hpr_rise;                  // Host request asserted.
  logic        no_fault;                  // Neither lockout nor thermal.
  logic [15:0] cyc_reg;                   // Timebase divider.
  logic        tick;                      // One-cycle timebase pulse.
  logic [14:0] wait_ms_reg;               // Time spent waiting.
  logic [14:0] press_ms_reg;              // Time the button is held.
  logic [14:0] down_ms_reg;               // Time since power-down began.
  logic        run_reg;                   // Sequencer running.
  logic        up_reg;                    // Direction, high for power-up.
  logic [3:0]  step_reg;                  // Step to fire next.
  logic [3:0]  step_next;                 // Step after this one.
  logic [7:0]  cnt_reg;                   // Remaining delay in ticks.
  logic        fire;                      // Current step fires now.
  logic        last_step;                 // Current step ends the run.
  logic [3:0]  delay_idx;                 // Delay that follows this step.
  logic [7:0]  delay_ms;                  // Clamped delay value.
  logic [7:0]  delay_ticks;               // Delay after the multiplier.
  rps_rails_t  hit;                       // Rails owned by the firing step.
  logic [14:0] long_limit;                // Selected long-press time.
  logic [15:0] rd_next;                   // Read mux output.

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Keeps a programmed delay inside the legal window.
  function automatic logic [7:0] clamp_delay(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v < `RPS_DELAY_MIN) begin
      r = `RPS_DELAY_MIN;
    end else if (v > `RPS_DELAY_MAX) begin
      r = `RPS_DELAY_MAX;
    end
    return r;
  endfunction

  // A brown-out behaves like reset, so the core restarts from off.
  assign core_rst = !RST_N || MAIN_SUPPLY_FAIL;

  //////////////////////////////////////////////////////////////////////////////
  // Input edges and timebase.

  // Previous pin levels feed the edge detectors.
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      pb_reg  <= 1'b1;
      sd_reg  <= 1'b1;
      hpr_reg <= 1'b0;
    end else begin
      pb_reg  <= POWER_BUTTON;
      sd_reg  <= SUPPLY_DETECT_PIN;
      hpr_reg <= HOST_POWER_REQUEST;
    end
  end

  assign pb_fall  = pb_reg && !POWER_BUTTON;
  assign sd_fall  = sd_reg && !SUPPLY_DETECT_PIN;
  assign hpr_rise = !hpr_reg && HOST_POWER_REQUEST;
  assign no_fault = !SUPPLY_UNDERVOLTAGE_LOCKOUT && !THERMAL_SHUTDOWN;

  // Free-running divider; every delay and hold timer counts its ticks.
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      cyc_reg <= 16'h0000;
    end else if (cyc_reg == TICK_TOP) begin
      cyc_reg <= 16'h0000;
    end else begin
      cyc_reg <= cyc_reg + 16'h0001;
    end
  end

  assign tick = (cyc_reg == TICK_TOP);

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond timers.

  // Waiting timer restarts whenever the waiting state is entered.
  // The waiting and hold timers saturate, so a stuck state never wraps back to zero.
  always_ff @(posedge CLK) begin
    if (core_rst || state_reg != RPS_WAIT) begin
      wait_ms_reg <= 15'h0000;
    end else if (tick && wait_ms_reg != `RPS_MS_MAX) begin
      wait_ms_reg <= wait_ms_reg + 15'h0001;
    end
  end

  // Button hold timer; any release clears it.
  always_ff @(posedge CLK) begin
    if (core_rst || POWER_BUTTON) begin
      press_ms_reg <= 15'h0000;
    end else if (tick && press_ms_reg != `RPS_MS_MAX) begin
      press_ms_reg <= press_ms_reg + 15'h0001;
    end
  end

  // Power-down window timer, zero from the cycle after the trigger.
  always_ff @(posedge CLK) begin
    if (core_rst || down_start) begin
      down_ms_reg <= 15'h0000;
    end else if (tick && state_reg == RPS_SHUTDOWN) begin
      down_ms_reg <= down_ms_reg + 15'h0001;
    end
  end

  assign long_limit = ctrl_reg.long_press_select ? `RPS_LONGER_MS : `RPS_LONG_MS;
  // The window is fixed; delay settings only shape steps inside it.
  assign down_end = (state_reg == RPS_SHUTDOWN) && (down_ms_reg == `RPS_DOWN_MS);

  //////////////////////////////////////////////////////////////////////////////
  // Power state decisions.

  // Faults take priority over a long press, which beats ordinary requests.
  always_comb begin
    state_next  = state_reg;
    target_next = target_reg;
    up_start    = 1'b0;
    down_start  = 1'b0;
    unique case (state_reg)
      RPS_OFF: begin
        // Off also wakes when main supply is present with detect grounded.
        if (no_fault && (pb_fall || sd_fall || hpr_rise ||
            (MAIN_SUPPLY_PRESENT && !SUPPLY_DETECT_PIN))) begin
          up_start = 1'b1;
        end
      end
      RPS_RECOVERY: begin
        // Recovery plays the pre-off role: edges only, no supply level.
        if (no_fault && (pb_fall || sd_fall || hpr_rise)) begin
          up_start = 1'b1;
        end
      end
      RPS_SUSPEND: begin
        if (!no_fault) begin
          down_start  = 1'b1;
          target_next = RPS_RECOVERY;
        end else if (press_ms_reg > long_limit) begin
          down_start  = 1'b1;
          target_next = RPS_OFF;
        end else if (pb_fall || sd_fall || HOST_POWER_REQUEST) begin
          up_start = 1'b1;
        end
      end
      RPS_WAIT, RPS_ACTIVE: begin
        // Regulation is judged only once the rails have finished coming up.
        if (!no_fault || (!run_reg && !RAILS_IN_REGULATION)) begin
          down_start  = 1'b1;
          target_next = RPS_RECOVERY;
        end else if (press_ms_reg > long_limit) begin
          down_start  = 1'b1;
          target_next = RPS_OFF;
        end else if (state_reg == RPS_ACTIVE) begin
          if (!HOST_POWER_REQUEST) begin
            down_start  = 1'b1;
            target_next = RPS_SUSPEND;
          end
        end else if (HOST_POWER_REQUEST) begin
          state_next = RPS_ACTIVE;
        end else if (POWER_BUTTON && SUPPLY_DETECT_PIN && wait_ms_reg >= `RPS_WAIT_MS) begin
          down_start  = 1'b1;
          target_next = RPS_OFF;
        end
      end
      RPS_SHUTDOWN: begin
        if (down_end) begin
          state_next = target_reg;
        end
      end
      default: begin
        state_next = RPS_OFF;
      end
    endcase
    if (up_start) begin
      state_next = RPS_WAIT;
    end
    if (down_start) begin
      state_next = RPS_SHUTDOWN;
    end
  end

  // State and target registers.
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      state_reg  <= RPS_OFF;
      target_reg <= RPS_OFF;
    end else begin
      state_reg  <= state_next;
      target_reg <= target_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Step sequencer.

  // Seal keeps the backup rails alive by ending the descent at step three.
  assign last_step = up_reg ? (step_reg == `RPS_STEP_LAST) :
                     (step_reg == `RPS_STEP_FIRST ||
                      (ctrl_reg.backup_rail_seal && step_reg == `RPS_STEP_SEALED));
  assign step_next = up_reg ? step_reg + 4'h1 : step_reg - 4'h1;
  // Delay n sits between steps n+1 and n+2 in either direction.
  assign delay_idx = up_reg ? step_reg - 4'h1 : step_reg - 4'h2;
  assign delay_ms  = clamp_delay(delay_reg[delay_idx]);
  // At most 5 ms times ten, so eight bits hold the product.
  assign delay_ticks = (!up_reg && ctrl_reg.shutdown_delay_multiplier) ?
                       8'(delay_ms * `RPS_DOWN_FACTOR) : delay_ms;
  assign fire = run_reg && (cnt_reg == 8'h00);

  // One step fires per pass; the delay then counts down in ticks.
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      run_reg  <= 1'b0;
      up_reg   <= 1'b1;
      step_reg <= `RPS_STEP_FIRST;
      cnt_reg  <= 8'h00;
    end else if (up_start) begin
      run_reg  <= 1'b1;
      up_reg   <= 1'b1;
      step_reg <= `RPS_STEP_FIRST;
      cnt_reg  <= 8'h00;
    end else if (down_start) begin
      // A power-up still in progress is abandoned in favour of the descent.
      run_reg  <= 1'b1;
      up_reg   <= 1'b0;
      step_reg <= `RPS_STEP_LAST;
      cnt_reg  <= 8'h00;
    end else if (down_end) begin
      run_reg <= 1'b0;
    end else if (fire) begin
      if (last_step) begin
        run_reg <= 1'b0;
      end else begin
        step_reg <= step_next;
        cnt_reg  <= delay_ticks;
      end
    end else if (run_reg && tick) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Steps one and two belong to the backup rails only; code zero never matches.
  always_comb begin
    for (int i = 0; i < RPS_NRAIL; i++) begin
      hit[i] = fire && (code_reg[i] == step_reg) && (code_reg[i] != `RPS_STEP_NONE) &&
               (step_reg > `RPS_STEP_BACKUP || i >= `RPS_BACKUP_A);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Rail enables and discharge.

  // Pins and read data both copy the enable register one cycle later, so reads match the pins.
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      en_reg  <= '0;
      dis_reg <= '1;
    end else if (fire) begin
      for (int i = 0; i < RPS_NRAIL; i++) begin
        if (hit[i]) begin
          en_reg[i]  <= up_reg;
          dis_reg[i] <= !up_reg;
        end
      end
    end else if (down_start && target_next != RPS_SUSPEND) begin
      // Unsequenced converters, regulator and switch one drop immediately.
      for (int i = 0; i < `RPS_UNSEQ_TOP; i++) begin
        if (code_reg[i] == `RPS_STEP_NONE) begin
          en_reg[i]  <= 1'b0;
          dis_reg[i] <= 1'b1;
        end
      end
    end else if (down_end && target_reg != RPS_SUSPEND) begin
      // Toward suspend nothing unsequenced is touched.
      en_reg[`RPS_LS_TWO]    <= 1'b0;
      en_reg[`RPS_LS_THREE]  <= 1'b0;
      dis_reg[`RPS_LS_TWO]   <= 1'b1;
      dis_reg[`RPS_LS_THREE] <= 1'b1;
    end else if (WR_EN && ADDR == `RPS_A_ENABLE && !run_reg) begin
      // Writes during a sequence are dropped, so software cannot race it.
      en_reg  <= WR_DATA[RPS_NRAIL-1:0];
      dis_reg <= ~WR_DATA[RPS_NRAIL-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Codes and delays may be rewritten at any time; a running sequence sees the change.
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      ctrl_reg <= `RPS_CTRL_RESET;
      for (int i = 0; i < RPS_NRAIL; i++) begin
        code_reg[i] <= CODE_RESET[i*4 +: 4];
      end
      for (int i = 0; i < RPS_NDELAY; i++) begin
        delay_reg[i] <= `RPS_DELAY_RESET;
      end
    end else if (WR_EN) begin
      if (ADDR == `RPS_A_CTRL) begin
        ctrl_reg <= rps_ctrl_t'(WR_DATA[2:0]);
      end
      for (int i = 0; i < RPS_NRAIL; i++) begin
        if (ADDR == `RPS_A_CODE0 + 8'(i)) begin
          code_reg[i] <= WR_DATA[3:0];
        end
      end
      for (int i = 0; i < RPS_NDELAY; i++) begin
        if (ADDR == `RPS_A_DELAY0 + 8'(i)) begin
          delay_reg[i] <= WR_DATA[7:0];
        end
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_next = 16'h0000;
    if (ADDR == `RPS_A_CTRL) begin
      rd_next = {13'h0000, ctrl_reg};
    end else if (ADDR == `RPS_A_ENABLE) begin
      rd_next = {6'h00, en_reg};
    end else if (ADDR >= `RPS_A_CODE0 && ADDR <= `RPS_A_CODE9) begin
      rd_next = {12'h000, code_reg[4'(ADDR - `RPS_A_CODE0)]};
    end else if (ADDR >= `RPS_A_DELAY0 && ADDR <= `RPS_A_DELAY8) begin
      rd_next = {8'h00, delay_reg[4'(ADDR - `RPS_A_DELAY0)]};
    end else if (ADDR == `RPS_A_STATUS) begin
      rd_next = {4'h0, up_reg, run_reg, step_reg, state_reg};
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge CLK) begin
    if (core_rst || !RD_EN) begin
      RD_DATA <= 16'h0000;
    end else begin
      RD_DATA <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output flops.

  // Outputs follow their registers one cycle later.
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      RAIL_ENABLE    <= '0;
      RAIL_DISCHARGE <= '1;
      STATE          <= RPS_OFF;
      SEQUENCER_BUSY <= 1'b0;
    end else begin
      RAIL_ENABLE    <= en_reg;
      RAIL_DISCHARGE <= dis_reg;
      STATE          <= state_reg;
      SEQUENCER_BUSY <= run_reg;
    end
  end

endmodule

`default_nettype wire

// ===== test/rps_host_model.sv
// Host processor, push-button and supply detector facing the sequencer.
// Assumes the bench commands presses and host readiness on clk edges.
`timescale 1ns/1ps
`default_nettype none
module rps_host_model #(
  parameter int HOST_LAT = 3
) (
  // Clock, reset and commands.
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic press,
  input  wire logic host_en,
  input  wire logic detect,
  // Pins toward the sequencer.
  output wire logic button_n,
  output wire logic detect_n,
  output var  logic request
);
  // The button shorts to ground; its pull-up makes idle read high.
  assign button_n = ~press;
  // The detector pulls its pin low against a pull-up, so idle reads high.
  assign detect_n = ~detect;
  // Firmware needs a few cycles after boot before it asserts its request.
  logic [3:0] lat_reg;
  always_ff @(posedge clk) begin
    if (!rst_n || !host_en) begin
      lat_reg <= 4'h0;
      request <= 1'b0;
    end else if (lat_reg == 4'(HOST_LAT)) begin
      request <= 1'b1;
    end else begin
      lat_reg <= lat_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== test/rps_tb_top.sv
// Self-checking bench for the rail power sequencer.
// Assumes the package, design, checker and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rps_regs.svh"
module rps_tb_top
  import rps_pkg::*;
  ;
  localparam int TICK = 4; // Short timebase keeps the run brief.
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, press = 1'b0, host_en = 1'b0;
  logic thermal = 1'b0, supply_fail = 1'b0, detect = 1'b0, busy, button_n, detect_n, request;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wr_data = 16'h0000, rd_data;
  logic [9:0]  rail_en, rail_dis;
  logic [5:0]  state;
  int errors = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  rps_top #(.TICK_CYCLES(TICK)) dut_u (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
    .POWER_BUTTON(button_n), .SUPPLY_DETECT_PIN(detect_n), .HOST_POWER_REQUEST(request),
    .MAIN_SUPPLY_PRESENT(1'b1), .MAIN_SUPPLY_FAIL(supply_fail),
    .SUPPLY_UNDERVOLTAGE_LOCKOUT(1'b0), .THERMAL_SHUTDOWN(thermal),
    .RAILS_IN_REGULATION(1'b1), .RAIL_ENABLE(rail_en), .RAIL_DISCHARGE(rail_dis),
    .STATE(state), .SEQUENCER_BUSY(busy));
  rps_host_model host_u (.clk(clk), .rst_n(rst_n), .press(press), .host_en(host_en),
    .detect(detect), .button_n(button_n), .detect_n(detect_n), .request(request));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk("rd_data", rd_data, exp);
  endtask
  // Bounded waits; running out ends the run as a failure.
  task automatic wait_for(input logic [5:0] s, input logic idle, input int lim);
    repeat (lim) begin
      if ((idle && busy === 1'b0) || (!idle && state === s)) break;
      @(posedge clk);
      #1;
    end
    if (!((idle && busy === 1'b0) || (!idle && state === s))) begin
      // A timeout counts only if the awaited state, or the idle sequencer, is still not seen after the last wait.
      chk("wait_timeout", 16'h0001, 16'h0000);
      finish_test();
    end
  endtask
  task automatic tap();
    @(posedge clk);
    press <= 1'b1;
    repeat (8) @(posedge clk);
    press <= 1'b0;
  endtask
  task automatic host(input logic on);
    @(posedge clk);
    host_en <= on;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`RPS_A_CTRL, 16'h0000);
    rd(`RPS_A_CODE0, 16'h0003);
    rd(`RPS_A_CODE0 + 8'h08, 16'h0001);
    rd(8'h40, 16'h0000);
    wr(`RPS_A_DELAY8, 16'h0005);
    rd(`RPS_A_DELAY8, 16'h0005);
    wr(`RPS_A_CTRL, 16'h0001);
    // Power-up by button; the enable write during the run must be dropped.
    tap();
    wait_for(RPS_WAIT, 1'b0, 20);
    wr(`RPS_A_ENABLE, 16'h03ff);
    wait_for(RPS_WAIT, 1'b1, 400);
    chk("rail_enable", {6'h00, rail_en}, 16'h033f);
    host(1'b1);
    wait_for(RPS_ACTIVE, 1'b0, 50);
    wr(`RPS_A_ENABLE, 16'h037f);
    rd(`RPS_A_ENABLE, 16'h037f);
    // Stretched power-down into suspend still ends on time.
    host(1'b0);
    wait_for(RPS_SUSPEND, 1'b0, 3000);
    chk("rail_enable", {6'h00, rail_en}, 16'h0040);
    chk("discharge", {6'h00, rail_dis}, 16'h03bf);
    host(1'b1);
    wait_for(RPS_ACTIVE, 1'b0, 100);
    wait_for(RPS_ACTIVE, 1'b1, 800);
    chk("rail_enable", {6'h00, rail_en}, 16'h037f);
    // Rail 0 leaves the sequence, so a fault drops it at once.
    wr(`RPS_A_CODE0, 16'h0000);
    // Thermal fault ends in recovery with every rail off; a press is ignored.
    @(posedge clk);
    thermal <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("rail_enable", {6'h00, rail_en}, 16'h037e);
    wait_for(RPS_RECOVERY, 1'b0, 3000);
    chk("rail_enable", {6'h00, rail_en}, 16'h0000);
    tap();
    repeat (10) @(posedge clk);
    #1;
    chk("state", {10'h000, state}, {10'h000, RPS_RECOVERY});
    @(posedge clk);
    thermal <= 1'b0;
    host(1'b0);
    // Sealed backup rails survive power-down.
    wr(`RPS_A_CTRL, 16'h0002);
    tap();
    wait_for(RPS_WAIT, 1'b0, 20);
    host(1'b1);
    wait_for(RPS_ACTIVE, 1'b0, 800);
    wait_for(RPS_ACTIVE, 1'b1, 800);
    chk("rail_enable", {6'h00, rail_en}, 16'h033e);
    host(1'b0);
    wait_for(RPS_SUSPEND, 1'b0, 3000);
    chk("rail_enable", {6'h00, rail_en}, 16'h0300);
    @(posedge clk);
    supply_fail <= 1'b1;
    repeat (2) @(posedge clk);
    supply_fail <= 1'b0;
    @(posedge clk);
    #1;
    chk("rail_enable", {6'h00, rail_en}, 16'h0000);
    chk("discharge", {6'h00, rail_dis}, 16'h03ff);
    // Detect pulled low wakes from off; a long hold then powers down.
    @(posedge clk);
    detect <= 1'b1;
    wait_for(RPS_WAIT, 1'b0, 20);
    @(posedge clk);
    press <= 1'b1;
    wait_for(RPS_SHUTDOWN, 1'b0, 33000);
    finish_test();
  end
endmodule
bind rps_top rps_top_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (.CLK(CLK), .RST_N(RST_N),
  .POWER_BUTTON(POWER_BUTTON), .HOST_POWER_REQUEST(HOST_POWER_REQUEST),
  .MAIN_SUPPLY_FAIL(MAIN_SUPPLY_FAIL), .SUPPLY_UNDERVOLTAGE_LOCKOUT(SUPPLY_UNDERVOLTAGE_LOCKOUT),
  .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .RAIL_ENABLE(RAIL_ENABLE),
  .RAIL_DISCHARGE(RAIL_DISCHARGE), .STATE(STATE));
`default_nettype wire

// ===== test/rps_top_sva.sv
// Port-level checker for the rail power sequencer.
// Assumes it is bound to rps_top with the same TICK_CYCLES.
`timescale 1ns/1ps
`default_nettype none
module rps_top_sva
  import rps_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset.
  input wire logic        CLK,
  input wire logic        RST_N,
  // Wake and fault pins.
  input wire logic        POWER_BUTTON,
  input wire logic        HOST_POWER_REQUEST,
  input wire logic        MAIN_SUPPLY_FAIL,
  input wire logic        SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input wire logic        THERMAL_SHUTDOWN,
  // Rails and state.
  input wire logic [9:0]  RAIL_ENABLE,
  input wire logic [9:0]  RAIL_DISCHARGE,
  input wire logic [5:0]  STATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles spent in power-down; the exit moment must not depend on delay settings.
  int  sd_cnt_reg;
  wire fault = SUPPLY_UNDERVOLTAGE_LOCKOUT | THERMAL_SHUTDOWN;
  always_ff @(posedge CLK) begin
    if (!RST_N || STATE != RPS_SHUTDOWN) begin
      sd_cnt_reg <= 0;
    end else begin
      sd_cnt_reg <= sd_cnt_reg + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wait_seen;
    ##[2:4] STATE == RPS_WAIT;
  endsequence
  property p_reset;
    disable iff (1'b0) (!RST_N) [*2] |=> STATE == RPS_OFF && RAIL_ENABLE == 10'h000;
  endproperty
  a_reset: assert property (p_reset) else $error("rails not off in reset");
  property p_supply_fail;
    MAIN_SUPPLY_FAIL [*2] |=> RAIL_ENABLE == 10'h000 && RAIL_DISCHARGE == 10'h3ff;
  endproperty
  a_supply_fail: assert property (p_supply_fail) else $error("rails live on fail");
  property p_wake;
    STATE == RPS_OFF && $fell(POWER_BUTTON) && !fault |-> s_wait_seen;
  endproperty
  a_wake: assert property (p_wake) else $error("button did not wake");
  property p_fault_block;
    ((STATE == RPS_OFF || STATE == RPS_RECOVERY) && fault) [*4] |=> $stable(STATE);
  endproperty
  a_fault_block: assert property (p_fault_block) else $error("woke under fault");
  property p_first_step;
    $rose(STATE == RPS_WAIT) |-> ##[0:2] RAIL_ENABLE[8];
  endproperty
  a_first_step: assert property (p_first_step) else $error("step one missing");
  property p_active_req;
    STATE == RPS_WAIT && HOST_POWER_REQUEST && !fault |-> ##[0:4] STATE == RPS_ACTIVE;
  endproperty
  a_active_req: assert property (p_active_req) else $error("request ignored");
  property p_active_down;
    STATE == RPS_ACTIVE && $fell(HOST_POWER_REQUEST) |-> ##[1:4] STATE == RPS_SHUTDOWN;
  endproperty
  a_active_down: assert property (p_active_down) else $error("no power-down");
  property p_down_len;
    $fell(STATE == RPS_SHUTDOWN) |->
      sd_cnt_reg >= 500 * TICK_CYCLES - 2 && sd_cnt_reg <= 501 * TICK_CYCLES + 2;
  endproperty
  a_down_len: assert property (p_down_len) else $error("power-down length off");
  property p_suspend_keep;
    STATE == RPS_SHUTDOWN ##1 STATE == RPS_SUSPEND |-> $stable(RAIL_ENABLE[7:6]);
  endproperty
  a_suspend_keep: assert property (p_suspend_keep) else $error("switch lost");
endmodule
`default_nettype wire
